// ==== rtl/rsc_device.sv ====
// device end: samples straps at reset release and runs clock-stop states
`timescale 1ns/10ps
module rsc_device
  import rsc_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // strap link
  rsc_link_if.device link,
  // core-side requests
  input wire logic i_prio_snoop,
  input wire logic i_sym_snoop,
  input wire logic i_intr,
  // status
  output logic [31:0] o_poc,
  output logic o_intc_enable,
  output logic [1:0] o_pwr_state,
  output logic o_prio_snoop_ack,
  output logic o_sym_snoop_ack,
  output logic o_intr_latched,
  output logic [4:0] o_core_ratio
);

  // strap link, counted in bus clock edges:
  //   release edge: first edge that sees reset_n high after low
  //   straps are sampled at the release edge only
  //   the word and the intc enable are visible after that edge
  //   strap moves after the release edge never reach the word
  // power states, counted in bus clock edges:
  //   stop request seen low while running: leave run after that edge
  //   quick start or stop grant, as chosen by the captured word
  //   request seen high again: back to run after that edge
  // snoops and interrupts:
  //   requests are levels, sampled at every edge after the release edge
  //   acknowledges repeat the request level, one edge after the request; the symmetric one stays low in quick start
  //   the interrupt latch stays set until the next link reset
  // configuration word layout:
  //   bit 5: quick start enabled at reset
  //   bits 19:18: bus frequency code
  //   bits 27 and 25:22: fused core-to-bus ratio code
  //   every other bit reads zero
  // intc strap:
  //   data line 0 low at release: controller off until next reset
  //   otherwise the controller comes out of reset enabled
  // limitation: the core clock itself is not generated here;
  //   the fused ratio is only reported for the clock unit to use

  // every flop of the device lives in this one struct
  typedef struct packed {
    // reset_n seen at the previous edge, marks the release edge
    logic reset_d;
    // captured configuration word, read-only to software
    logic [31:0] poc;
    // global enable of the local interrupt controller
    logic intc_en;
    // power state
    rsc_pwr_t pwr;
    // priority snoop acknowledge, the request level one edge later
    logic prio_ack;
    // symmetric snoop acknowledge, the request level one edge later outside quick start
    logic sym_ack;
    // sticky interrupt latch
    logic intr;
  } rsc_dev_st_t;

  // value after the asynchronous reset, constants only
  localparam rsc_dev_st_t DEV_RESET = '{
    reset_d: 1'b0,
    poc: POC_RESET,
    intc_en: INTC_EN_RESET,
    pwr: RSC_RUN,
    prio_ack: 1'b0,
    sym_ack: 1'b0,
    intr: 1'b0
  };

  rsc_dev_st_t st, next_st;

  // quick start blocks symmetric snoops and interrupt latching;
  // one decode for both keeps the two paths from disagreeing
  function automatic logic qs_blocks(rsc_pwr_t pwr);
    return pwr == RSC_QUICK_START;
  endfunction

  // one edge of the power state machine, link out of reset
  function automatic rsc_pwr_t pwr_step(rsc_pwr_t pwr, logic stop_req, logic qs_en);
    rsc_pwr_t nxt;
    nxt = pwr;
    // codes are Gray along run to either state and back
    case (pwr)
      RSC_RUN: begin
        if (stop_req) begin
          // which low-power state was fixed at the release edge
          nxt = qs_en ? RSC_QUICK_START : RSC_STOP_GRANT;
        end
      end
      RSC_STOP_GRANT, RSC_QUICK_START: begin
        // request withdrawn: wake up
        if (!stop_req) begin
          nxt = RSC_RUN;
        end
      end
      default: begin
        // unused code: fall back to run rather than lock up
        nxt = RSC_RUN;
      end
    endcase
    return nxt;
  endfunction

  // builds the configuration word from sampled straps and fuse
  function automatic logic [31:0] build_poc(logic qs, logic [1:0] sel);
    logic [31:0] w;
    // unused bits read as zero
    w = POC_RESET;
    w[POC_QS_BIT] = qs;
    // strap select 01 is the 100 MHz setting; re-encode per word layout
    case (sel)
      2'h0: w[POC_FREQ_LSB +: 2] = FREQ_66;
      2'h1: w[POC_FREQ_LSB +: 2] = FREQ_100;
      2'h3: w[POC_FREQ_LSB +: 2] = FREQ_133;
      // reserved select: report the slowest speed
      default: w[POC_FREQ_LSB +: 2] = FREQ_66;
    endcase
    // ratio comes from the fuse, never from a strap
    w[POC_RATIO_LO_LSB +: 4] = FUSED_RATIO[3:0];
    w[POC_RATIO_HI_BIT] = FUSED_RATIO[4];
    return w;
  endfunction

  // ratio field of the word, reassembled from its two parts
  function automatic logic [4:0] ratio_of(logic [31:0] word);
    return {word[POC_RATIO_HI_BIT], word[POC_RATIO_LO_LSB +: 4]};
  endfunction

  // next state
  always_comb begin
    // defaults: hold everything, acknowledges are pulses
    next_st = st;
    next_st.reset_d = link.reset_n;
    next_st.prio_ack = 1'b0;
    next_st.sym_ack = 1'b0;
    if (!link.reset_n) begin
      // in reset: run state, latch clear, intc back on
      next_st.pwr = RSC_RUN;
      next_st.intr = 1'b0;
      next_st.intc_en = INTC_EN_RESET;
    end else if (!st.reset_d) begin
      // release edge: sample straps once; later strap moves are ignored
      next_st.poc = build_poc(link.quick_start_strap_line, link.bus_freq_sel);
      // data line 0 low clears the enable until the next reset
      next_st.intc_en = link.interrupt_bus_data_lines[0];
    end else begin
      // straps are no longer looked at from here on
      // power state follows the stop request
      next_st.pwr = pwr_step(st.pwr, !link.clock_stop_request_n, st.poc[POC_QS_BIT]);
      // priority snoops are served in every state
      next_st.prio_ack = i_prio_snoop;
      // symmetric snoops are dropped in quick start
      next_st.sym_ack = i_sym_snoop && !qs_blocks(st.pwr);
      // interrupts latch only with the intc on and outside quick start
      if (i_intr && st.intc_en && !qs_blocks(st.pwr)) begin
        next_st.intr = 1'b1;
      end
    end
  end

  // state register; i_ce low freezes every field
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    // asynchronous branch loads constants only
    if (!i_arst_n) begin
      st <= DEV_RESET;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // configuration word and intc enable straight from state
  assign o_poc = st.poc;
  assign o_intc_enable = st.intc_en;
  // power state code as defined in the package
  assign o_pwr_state = st.pwr;
  // acknowledge pulses
  assign o_prio_snoop_ack = st.prio_ack;
  assign o_sym_snoop_ack = st.sym_ack;
  // interrupt latch
  assign o_intr_latched = st.intr;
  // ratio is the fuse, never a strap
  assign o_core_ratio = ratio_of(st.poc);

endmodule // rsc_device

// ==== common/rsc_pkg.sv ====
// package: constants and types shared by both ends of the reset strap link
package rsc_pkg;
  // power-on configuration word layout
  localparam int POC_QS_BIT = 5;
  localparam int POC_FREQ_LSB = 18;
  localparam int POC_RATIO_LO_LSB = 22;
  localparam int POC_RATIO_HI_BIT = 27;
  localparam logic [1:0] FREQ_66 = 2'h0;
  localparam logic [1:0] FREQ_100 = 2'h2;
  localparam logic [1:0] FREQ_133 = 2'h1;
  // fused core-to-bus ratio code, arbitrary default
  localparam logic [4:0] FUSED_RATIO = 5'h05;
  // reset values
  localparam logic [31:0] POC_RESET = 32'h0000_0000;
  localparam logic INTC_EN_RESET = 1'b1;
  // host register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_POC = 8'h08;
  // host control field positions
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_QS_BIT = 1;
  localparam int CTRL_INTC_OFF_BIT = 2;
  localparam int CTRL_STOP_BIT = 3;
  // device power states; one bit flips from run to either low-power state
  typedef enum logic [1:0] {
    RSC_RUN = 2'h0,
    RSC_STOP_GRANT = 2'h1,
    RSC_QUICK_START = 2'h2
  } rsc_pwr_t;
endpackage

// ==== common/rsc_link_if.sv ====
// interface: strap and control lines between central agent and device
`timescale 1ns/10ps
interface rsc_link_if;
  logic reset_n;
  logic clock_stop_request_n;
  logic quick_start_strap_line;
  logic [1:0] interrupt_bus_data_lines;
  logic interrupt_bus_clock;
  logic [1:0] bus_freq_sel;
  modport device (
    input reset_n, clock_stop_request_n, quick_start_strap_line,
    input interrupt_bus_data_lines, interrupt_bus_clock, bus_freq_sel
  );
  modport agent (
    output reset_n, clock_stop_request_n, quick_start_strap_line,
    output interrupt_bus_data_lines, interrupt_bus_clock, bus_freq_sel
  );
endinterface

// ==== rtl/rsc_agent.sv ====
// agent end: APB-controlled driver of reset and strap lines
`timescale 1ns/10ps
module rsc_agent
  import rsc_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // device status fed back
  input wire logic [31:0] i_poc,
  input wire logic [1:0] i_pwr_state,
  // strap link
  rsc_link_if.agent link
);

  typedef struct packed {
    logic [3:0] ctrl;
    logic [31:0] rdata;
    logic slverr;
    logic pready;
  } rsc_agt_st_t;

  rsc_agt_st_t st, next_st;

  // apb: ready flops high for the access phase; read data registered at setup
  always_comb begin
    next_st = st;
    next_st.pready = i_psel && !i_penable;
    if (i_psel && !i_penable) begin
      next_st.slverr = 1'b0;
      next_st.rdata = 32'h0000_0000;
      case (i_paddr)
        REG_CTRL: next_st.rdata = {28'h000_0000, st.ctrl};
        REG_STAT: next_st.rdata = {30'h0, i_pwr_state};
        REG_POC: next_st.rdata = i_poc;
        default: next_st.slverr = 1'b1;
      endcase
    end
    // write lands only at the edge where ready is seen high
    if (i_psel && i_penable && st.pready && i_pwrite && i_paddr == REG_CTRL) begin
      next_st.ctrl = i_pwdata[3:0];
    end
  end

  // state register; device held in reset until software releases it
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '{ctrl: 4'h0, rdata: 32'h0000_0000, slverr: 1'b0, pready: 1'b0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_prdata = st.rdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.slverr;
  assign link.reset_n = st.ctrl[CTRL_RESET_BIT];
  assign link.quick_start_strap_line = st.ctrl[CTRL_QS_BIT];
  assign link.clock_stop_request_n = !st.ctrl[CTRL_STOP_BIT];
  // enabled intc: both lines high and clock running; disabled: clock low
  assign link.interrupt_bus_data_lines = {1'b1, !st.ctrl[CTRL_INTC_OFF_BIT]};
  assign link.interrupt_bus_clock = st.ctrl[CTRL_INTC_OFF_BIT] ? 1'b0 : i_clk_sys;
  assign link.bus_freq_sel = 2'h1;

endmodule // rsc_agent

// ==== bench/rsc_props.sv ====
// checker: strap capture, config word and power-state properties
`timescale 1ns/10ps
module rsc_props
  import rsc_pkg::*;
(
  // clock, reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // link lines
  input wire logic reset_n,
  input wire logic clock_stop_request_n,
  input wire logic quick_start_strap_line,
  input wire logic [1:0] interrupt_bus_data_lines,
  input wire logic [1:0] bus_freq_sel,
  // device status
  input wire logic [31:0] o_poc,
  input wire logic o_intc_enable,
  input wire logic [1:0] o_pwr_state,
  input wire logic [4:0] o_core_ratio,
  input wire logic i_prio_snoop,
  input wire logic o_prio_snoop_ack,
  input wire logic i_sym_snoop,
  input wire logic o_sym_snoop_ack,
  input wire logic o_intr_latched
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // capture point: first edge with reset_n high after low
  sequence s_cap; $rose(reset_n); endsequence
  sequence s_qs; o_pwr_state == RSC_QUICK_START; endsequence
  property p_qs; s_cap |=> o_poc[POC_QS_BIT] == $past(quick_start_strap_line); endproperty
  property p_freq; s_cap |=> o_poc[POC_FREQ_LSB +: 2] == FREQ_100; endproperty
  property p_intc_rst; !reset_n |=> o_intc_enable; endproperty
  property p_bsel; s_cap |-> bus_freq_sel == 2'h1; endproperty
  property p_intc; s_cap |=> o_intc_enable == $past(interrupt_bus_data_lines[0]); endproperty
  property p_ratio; s_cap |=> {o_poc[POC_RATIO_HI_BIT], o_poc[POC_RATIO_LO_LSB +: 4]} == FUSED_RATIO
    && o_core_ratio == FUSED_RATIO; endproperty
  // three edges released: the word has settled and must not move
  property p_hold; reset_n && $past(reset_n) && $past(reset_n, 2) |-> $stable(o_poc); endproperty
  property p_stop; reset_n && $past(reset_n) && o_pwr_state == RSC_RUN && !clock_stop_request_n
    |=> o_pwr_state == (o_poc[POC_QS_BIT] ? RSC_QUICK_START : RSC_STOP_GRANT); endproperty
  property p_exit; o_pwr_state != RSC_RUN && clock_stop_request_n |=> o_pwr_state == RSC_RUN; endproperty
  property p_prio; s_qs and $rose(i_prio_snoop) |=> o_prio_snoop_ack; endproperty
  property p_sym; s_qs and i_sym_snoop |=> !o_sym_snoop_ack; endproperty
  property p_intr; s_qs and !o_intr_latched |=> !o_intr_latched; endproperty
  a_qs: assert property (p_qs) else $error("quick start bit wrong");
  a_freq: assert property (p_freq) else $error("bus frequency code wrong");
  a_bsel: assert property (p_bsel) else $error("bus strap not 100 MHz");
  a_intc: assert property (p_intc) else $error("intc enable wrong");
  a_intc_rst: assert property (p_intc_rst) else $error("intc not enabled in reset");
  a_ratio: assert property (p_ratio) else $error("ratio code wrong");
  a_hold: assert property (p_hold) else $error("config word moved");
  a_stop: assert property (p_stop) else $error("wrong stop state");
  a_exit: assert property (p_exit) else $error("no return to run");
  a_prio: assert property (p_prio) else $error("priority snoop not served");
  a_sym: assert property (p_sym) else $error("symmetric snoop served");
  a_intr: assert property (p_intr) else $error("interrupt latched in quick start");
endmodule // rsc_props

// ==== bench/rsc_tb.sv ====
// testbench: both ends joined, driven over apb
`timescale 1ns/10ps
module reset_strap_configuration_tb
  import rsc_pkg::*;
;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic prio = 1'b0, sym = 1'b0, intr = 1'b0, pready, pslverr, intc_en, pack, sack, ilat, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, poc, rd;
  logic [1:0] pwr;
  logic [4:0] ratio;
  int err_count = 0, total_checks = 0, cyc = 0;
  rsc_link_if link_if();
  rsc_device rsc_device_inst(.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(1'b1), .link(link_if),
    .i_prio_snoop(prio), .i_sym_snoop(sym), .i_intr(intr), .o_poc(poc), .o_intc_enable(intc_en),
    .o_pwr_state(pwr), .o_prio_snoop_ack(pack), .o_sym_snoop_ack(sack), .o_intr_latched(ilat), .o_core_ratio(ratio));
  rsc_agent rsc_agent_inst(.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_poc(poc), .i_pwr_state(pwr), .link(link_if));
  rsc_props rsc_props_inst(.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .reset_n(link_if.reset_n),
    .clock_stop_request_n(link_if.clock_stop_request_n), .quick_start_strap_line(link_if.quick_start_strap_line),
    .interrupt_bus_data_lines(link_if.interrupt_bus_data_lines), .bus_freq_sel(link_if.bus_freq_sel), .o_poc(poc),
    .o_intc_enable(intc_en), .o_pwr_state(pwr), .o_core_ratio(ratio), .i_prio_snoop(prio), .o_prio_snoop_ack(pack),
    .i_sym_snoop(sym), .o_sym_snoop_ack(sack), .o_intr_latched(ilat));
  always #4 i_clk_sys = ~i_clk_sys;
  // hang guard: whole run needs about 120 cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // apb transfer; no latency assumed, waits for pready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_bus;
    xfer(1'b0, REG_POC, 32'h0);
    chk(rd, POC_RESET);
    xfer(1'b1, 8'h0C, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("t_bus done");
  endtask
  // boot with given straps, then disturb straps, stop and wake
  task t_boot(input logic qs, input logic off);
    logic [31:0] v, snap;
    v = {29'h0, off, qs, 1'b0};
    xfer(1'b1, REG_CTRL, v);
    xfer(1'b1, REG_CTRL, v | 32'h1);
    xfer(1'b0, REG_POC, 32'h0);
    snap = rd;
    chk(rd[POC_QS_BIT], qs);
    chk(rd[19:18], FREQ_100);
    chk({rd[27], rd[25:22]}, FUSED_RATIO);
    chk(intc_en, !off);
    chk(link_if.interrupt_bus_data_lines, {1'b1, !off});
    chk(off ? link_if.interrupt_bus_clock : 1'b0, 1'b0);
    xfer(1'b1, REG_CTRL, (v ^ 32'h6) | 32'h1);
    xfer(1'b1, REG_POC, 32'hFFFF_FFFF);
    xfer(1'b0, REG_POC, 32'h0);
    chk(rd, snap);
    xfer(1'b1, REG_CTRL, v | 32'h9);
    xfer(1'b0, REG_STAT, 32'h0);
    chk(rd[1:0], qs ? RSC_QUICK_START : RSC_STOP_GRANT);
    {prio, sym, intr} <= 3'h7;
    @(posedge i_clk_sys);
    {prio, sym, intr} <= 3'h0;
    #1;
    chk(pack, 1'b1);
    chk(sack, !qs);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk(pack, 1'b0);
    chk(ilat, !off && !qs);
    xfer(1'b1, REG_CTRL, v | 32'h1);
    xfer(1'b0, REG_STAT, 32'h0);
    chk(rd[1:0], RSC_RUN);
    $display("t_boot qs=%0d off=%0d done", qs, off);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    t_bus();
    t_boot(1'b0, 1'b0);
    t_boot(1'b1, 1'b1);
    t_boot(1'b1, 1'b0);
    end_sim();
  end
endmodule // reset_strap_configuration_tb
